/* File: pkg/rsc_if.sv */
// carrier between the controller and its release timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface rsc_if #(
  parameter int CNT_W = 18
);
  logic             clk;
  logic             async_hold_n;
  logic             sync_hold;
  logic [CNT_W-1:0] delay_cycles;
  logic             hold;

  modport ctrl (
    output clk,
    output async_hold_n,
    output sync_hold,
    output delay_cycles,
    input  hold
  );
  modport timer (
    input  clk,
    input  async_hold_n,
    input  sync_hold,
    input  delay_cycles,
    output hold
  );
endinterface
`default_nettype wire

/* File: pkg/rsc_pkg.sv */
// constants of the reset source controller: register map, flag positions,
// fuse codes and timing counts; assumes a 10 MHz system clock
package rsc_pkg;

  localparam int RSC_CLK_HZ = 10_000_000;
  localparam int RSC_CLK_NS = 100;

  // one status register on the lite bus, byte address
  localparam logic [3:0] RSC_STATUS_OFS = 4'h0;
  localparam int         RSC_STATUS_W   = 8;
  localparam int         RSC_FLAG_W     = 5;

  // flag positions inside the status register
  localparam int RSC_POR_BIT    = 0;
  localparam int RSC_PIN_BIT    = 1;
  localparam int RSC_SUPPLY_BIT = 2;
  localparam int RSC_WDOG_BIT   = 3;
  localparam int RSC_SCAN_BIT   = 4;

  // power-up of this logic counts as a power-on cause
  localparam logic [4:0] RSC_STATUS_RST = 5'h01;

  // supply trigger level fuse codes; all others reserved
  localparam logic [2:0] RSC_LVL_OFF = 3'h7;
  localparam logic [2:0] RSC_LVL_1V8 = 3'h6;
  localparam logic [2:0] RSC_LVL_2V7 = 3'h5;
  localparam logic [2:0] RSC_LVL_4V3 = 3'h4;

  // release delay: base period, scaled by the fuse settings
  localparam int RSC_TOUT_BASE_US  = 65;
  localparam int RSC_TOUT_BASE_CYC =
    (RSC_TOUT_BASE_US * (RSC_CLK_HZ / 1_000_000));

  // least supply dip that counts as a brown-out
  localparam int RSC_BOD_MIN_NS  = 200;
  localparam int RSC_BOD_MIN_CYC =
    (RSC_BOD_MIN_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
  localparam int RSC_BOD_CNT_W   = 4;

  // lite bus responses
  localparam logic [1:0] RSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RSC_RESP_SLVERR = 2'h2;
  localparam logic [1:0] RSC_RESP_DECERR = 2'h3;

endpackage

/* File: sim/rsc_far_side.sv */
// far side model: supply monitors, reset pin, watchdog, scan bit
// assumes the bench calls pulse from one process at a time
`timescale 1ns/1ps
`default_nettype none
module rsc_far_side (
  input  wire logic i_clk,
  output logic      o_supply_below_por,
  output logic      o_pin_reset_n,
  output logic      o_watchdog_expire,
  output logic      o_supply_below_trigger,
  output logic      o_scan_reset_bit
);
  // index matches the status flag of each source
  logic [4:0] act_reg = 5'h00;

  assign o_supply_below_por     = act_reg[0];
  assign o_pin_reset_n          = ~act_reg[1];
  assign o_supply_below_trigger = act_reg[2];
  assign o_watchdog_expire      = act_reg[3];
  assign o_scan_reset_bit       = act_reg[4];

  // one source for n clocks, n of 1 is a short dip
  task automatic pulse(input int b, input int n);
    @(posedge i_clk);
    act_reg[b] <= 1'h1;
    repeat (n) @(posedge i_clk);
    act_reg[b] <= 1'h0;
  endtask
endmodule
`default_nettype wire

/* File: sim/rsc_top_asserts.sv */
// checker of the reset source controller ports
// assumes it is bound onto rsc_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rsc_top_asserts
  import rsc_pkg::*;
#(
  parameter int TOUT_BASE_CYC = RSC_TOUT_BASE_CYC
) (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_supply_below_por,
  input wire logic       i_pin_reset_n,
  input wire logic       i_watchdog_expire,
  input wire logic       i_watchdog_enable,
  input wire logic       i_supply_below_trigger,
  input wire logic       i_scan_reset_bit,
  input wire logic [2:0] i_supply_trigger_level_fuses,
  input wire logic       o_internal_reset,
  input wire logic       o_port_reset,
  input wire logic       o_fetch_at_vector,
  input wire logic       o_supply_detector_enable
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic [15:0] quiet_reg;

  // level sources only, so the count is an upper bound of the delay
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      quiet_reg <= 16'h0;
    else if (!i_pin_reset_n || i_supply_below_por || i_scan_reset_bit)
      quiet_reg <= 16'h0;
    else if (quiet_reg != 16'hFFFF)
      quiet_reg <= quiet_reg + 16'h1;
  end

  a_port_follow: assert property (
    !i_pin_reset_n || i_supply_below_por |-> o_port_reset)
    else $error("port pins not held in reset");
  a_pin_hold: assert property (
    !i_pin_reset_n |-> o_internal_reset) else $error("pin low, no reset");
  a_por_hold: assert property (
    i_supply_below_por |-> o_internal_reset) else $error("por, no reset");
  a_scan_hold: assert property (
    i_scan_reset_bit |=> o_internal_reset) else $error("scan, no reset");
  a_wdog_reset: assert property (
    $rose(i_watchdog_expire) && i_watchdog_enable |-> ##2 o_internal_reset)
    else $error("watchdog expiry, no reset");
  a_dip_reset: assert property (
    (o_supply_detector_enable && i_supply_below_trigger) [*3]
    |-> ##[1:2] o_internal_reset) else $error("long dip, no reset");
  a_level_decode: assert property (
    1'h1 |=> o_supply_detector_enable ==
    ($past(i_supply_trigger_level_fuses) inside {3'h4, 3'h5, 3'h6}))
    else $error("detector enable decode wrong");
  a_fetch_pulse: assert property (
    $fell(o_internal_reset) |-> ##[0:2] o_fetch_at_vector
    ##1 !o_fetch_at_vector) else $error("fetch pulse wrong");
  a_release_wait: assert property (
    $fell(o_internal_reset) |-> quiet_reg >= TOUT_BASE_CYC)
    else $error("reset released before delay");

  c_wdog: cover property ($rose(i_watchdog_expire) && i_watchdog_enable);
  c_dip: cover property (o_supply_detector_enable && i_supply_below_trigger);
  c_fetch: cover property (o_fetch_at_vector);
endmodule

bind rsc_top rsc_top_asserts #(.TOUT_BASE_CYC(TOUT_BASE_CYC)) u_chk (.*);
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench of the reset source controller
// assumes rsc_top, its checker and the far side model are compiled
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rsc_pkg::*;
  localparam int TOUT = 4;
  logic        i_clk = 1'h0;
  logic        i_rst_n = 1'h0;
  logic        i_watchdog_enable = 1'h1;
  logic [2:0]  i_supply_trigger_level_fuses = 3'h6;
  logic [1:0]  i_startup_time_fuses = 2'h0;
  logic [3:0]  i_clock_select_fuses = 4'h0;
  logic [3:0]  s_axi_awaddr = 4'h0;
  logic [3:0]  s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic [31:0] rdat;
  logic [1:0]  rresp;
  logic [1:0]  bresp;
  int          n_errors = 0;
  int          samples_checked = 0;
  wire logic   i_supply_below_por, i_pin_reset_n, i_watchdog_expire;
  wire logic   i_supply_below_trigger, i_scan_reset_bit;
  wire logic   o_internal_reset, o_port_reset, o_fetch_at_vector;
  wire logic   o_supply_detector_enable, s_axi_awready, s_axi_wready;
  wire logic   s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  o_supply_trigger_level, s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;

  always #50 i_clk = ~i_clk;

  rsc_top #(.TOUT_BASE_CYC(TOUT)) u_dut (.*);
  rsc_far_side u_far (
    .i_clk(i_clk), .o_supply_below_por(i_supply_below_por),
    .o_pin_reset_n(i_pin_reset_n), .o_watchdog_expire(i_watchdog_expire),
    .o_supply_below_trigger(i_supply_below_trigger),
    .o_scan_reset_bit(i_scan_reset_bit));

  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge i_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    bresp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge i_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rdat = s_axi_rdata;
    rresp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic st(input logic [7:0] e);
    rd(RSC_STATUS_OFS);
    chk({24'h0, e}, rdat);
    chk({30'h0, RSC_RESP_OKAY}, {30'h0, rresp});
  endtask

  // bounded by the watchdog process while the reset is stretched
  task automatic settle;
    repeat (3) @(posedge i_clk);
    while (o_internal_reset !== 1'h0) @(posedge i_clk);
    repeat (3) @(posedge i_clk);
  endtask

  initial begin
    #2_000_000;
    n_errors++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'h1;
    settle();
    st(8'h01);
    wr(RSC_STATUS_OFS, 32'hFFFF_FFFF);
    chk({30'h0, RSC_RESP_OKAY}, {30'h0, bresp});
    st(8'h01);
    wr(RSC_STATUS_OFS, 32'h0);
    st(8'h00);
    for (int b = 1; b < 5; b++) begin
      u_far.pulse(b, 6);
      chk(32'h1, {31'h0, o_port_reset});
      settle();
      st(8'h01 << b);
      wr(RSC_STATUS_OFS, 32'h0);
    end
    i_watchdog_enable <= 1'h0;
    u_far.pulse(3, 6);
    repeat (10) @(posedge i_clk);
    st(8'h00);
    i_watchdog_enable <= 1'h1;
    u_far.pulse(2, 1);
    repeat (10) @(posedge i_clk);
    st(8'h00);
    for (int c = 0; c < 8; c++) begin
      i_supply_trigger_level_fuses <= c[2:0];
      u_far.pulse(2, 6);
      settle();
      chk({29'h0, (c >= 4 && c < 7), c[1:0]},
          {29'h0, o_supply_detector_enable, o_supply_trigger_level});
      st((c >= 4 && c < 7) ? 8'h04 : 8'h00);
      wr(RSC_STATUS_OFS, 32'h0);
    end
    u_far.pulse(4, 3);
    u_far.pulse(1, 3);
    settle();
    st(8'h12);
    u_far.pulse(0, 6);
    settle();
    st(8'h01);
    rd(4'h4);
    chk(32'h0, rdat);
    chk({30'h0, RSC_RESP_DECERR}, {30'h0, rresp});
    wr(4'h4, 32'h0);
    chk({30'h0, RSC_RESP_DECERR}, {30'h0, bresp});
    s_axi_wstrb <= 4'hE;
    wr(RSC_STATUS_OFS, 32'h0);
    st(8'h01);
    s_axi_wstrb <= 4'hF;
    wr(RSC_STATUS_OFS, 32'h0);
    st(8'h00);
    final_report();
  end
endmodule
`default_nettype wire

/* File: verilog/rsc_release_timer.sv */
// release timer: holds the internal reset and stretches its release
// assumes async_hold_n is a glitch-free combination of level sources
`timescale 1ns/1ps
`default_nettype none
module rsc_release_timer
  import rsc_pkg::*;
#(
  parameter int CNT_W = 18
) (
  rsc_if.timer bus
);

  typedef struct packed {
    logic             hold;
    logic [CNT_W-1:0] cnt;
  } rsc_tmr_t;

  rsc_tmr_t st_reg;
  rsc_tmr_t st_next;

  always_comb begin
    st_next = st_reg;
    if (bus.sync_hold) begin
      st_next.hold = 1'b1;
      st_next.cnt  = '0;
    end else if (st_reg.hold) begin
      if (st_reg.cnt >= bus.delay_cycles - CNT_W'(1)) begin
        st_next.hold = 1'b0;
        st_next.cnt  = '0;
      end else begin
        st_next.cnt = st_reg.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge bus.clk or negedge bus.async_hold_n) begin
    if (!bus.async_hold_n) begin
      st_reg <= '{hold: 1'b1, cnt: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.hold = st_reg.hold;

endmodule
`default_nettype wire

/* File: verilog/rsc_top.sv */
// reset source controller: merges five reset causes into the internal
// reset, stretches its release, and records the cause for software.
// assumes all inputs synchronous to i_clk; i_rst_n is the power-up reset
// of this logic itself; status register reached over a lite bus slave.
// the fuses are taken as static while the part runs; a fuse change only
// takes effect through the registered decode one cycle later.
// limitation: the delay table is a plain power-of-two scale of the base
// period, and the analog comparators live outside this block.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rsc_top
  import rsc_pkg::*;
#(
  parameter int ADDR_W        = 4,
  parameter int CNT_W         = 18,
  parameter int TOUT_BASE_CYC = RSC_TOUT_BASE_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // reset sources
  input  wire logic              i_supply_below_por,
  input  wire logic              i_pin_reset_n,
  input  wire logic              i_watchdog_expire,
  input  wire logic              i_watchdog_enable,
  input  wire logic              i_supply_below_trigger,
  input  wire logic              i_scan_reset_bit,
  // fuses
  input  wire logic [2:0]        i_supply_trigger_level_fuses,
  input  wire logic [1:0]        i_startup_time_fuses,
  input  wire logic [3:0]        i_clock_select_fuses,
  // reset outputs
  output logic                   o_internal_reset,
  output logic                   o_port_reset,
  output logic                   o_fetch_at_vector,
  output logic                   o_supply_detector_enable,
  output logic [1:0]             o_supply_trigger_level,
  // lite bus slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // the longest stretch is the base scaled by the widest shift of seven
  localparam longint MAX_DELAY = longint'(TOUT_BASE_CYC) << 7;
  localparam longint CNT_SPAN  = longint'(1) << CNT_W;

  // status decode stays in range at any width of the bus address
  localparam logic [ADDR_W-1:0] STATUS_ADDR = ADDR_W'(RSC_STATUS_OFS);

  // refuse widths the logic cannot serve
  if (ADDR_W < 3 || ADDR_W > 16) begin : g_chk_addr_w
    $error("rsc_top: ADDR_W out of range");
  end
  if (TOUT_BASE_CYC < 1 || CNT_W > 30 ||
      MAX_DELAY >= CNT_SPAN) begin : g_chk_cnt_w
    $error("rsc_top: delay counter too narrow");
  end

  typedef struct packed {
    // reset causes, their flags and the release bookkeeping
    logic [RSC_FLAG_W-1:0]    status;
    logic                     wd_pulse;
    logic                     wd_prev;
    logic [RSC_BOD_CNT_W-1:0] dip_cnt;
    logic                     brownout;
    logic                     hold_prev;
    logic                     fetch;
    logic                     det_en;
    logic [1:0]               level;
    logic [CNT_W-1:0]         delay;
    // lite bus write side
    logic                     awready;
    logic                     aw_got;
    logic [ADDR_W-1:0]        awaddr;
    logic                     wready;
    logic                     w_got;
    logic [7:0]               wdata;
    logic                     wlane;
    logic                     bvalid;
    logic [1:0]               bresp;
    // lite bus read side
    logic                     arready;
    logic                     rvalid;
    logic [7:0]               rdata;
    logic [1:0]               rresp;
  } rsc_state_t;

  rsc_state_t st_reg;
  rsc_state_t st_next;

  rsc_if #(.CNT_W(CNT_W)) tmr_bus ();

  logic       aw_fire;
  logic       w_fire;
  logic       ar_fire;
  logic       det_ok;
  logic [2:0] shift;

  assign aw_fire = s_axi_awvalid & st_reg.awready;
  assign w_fire  = s_axi_wvalid & st_reg.wready;
  assign ar_fire = s_axi_arvalid & st_reg.arready;

  // reserved codes leave detection off
  // the decode is registered, so the enable never glitches with the fuses
  always_comb begin
    det_ok = (i_supply_trigger_level_fuses == RSC_LVL_1V8) ||
             (i_supply_trigger_level_fuses == RSC_LVL_2V7) ||
             (i_supply_trigger_level_fuses == RSC_LVL_4V3);
  end

  // delay from startup and clock fuses
  assign shift = {i_startup_time_fuses, i_clock_select_fuses[0]};

  always_comb begin
    st_next = st_reg;

    // single-cycle watchdog pulse
    // taken on the rising edge only: a held expiry would otherwise
    // restart the delay every cycle
    st_next.wd_prev  = i_watchdog_expire;
    st_next.wd_pulse = i_watchdog_expire & i_watchdog_enable &
                       ~st_reg.wd_prev;

    st_next.det_en = det_ok;
    st_next.level  = i_supply_trigger_level_fuses[1:0];
    st_next.delay  = CNT_W'(TOUT_BASE_CYC) << shift;

    // dip filter before brown-out
    // a dip must be seen on two edges in a row; shorter ones are taken
    // as comparator noise and leave no trace in the flags
    if (!st_reg.det_en || !i_supply_below_trigger) begin
      st_next.dip_cnt  = '0;
      st_next.brownout = 1'b0;
    end else if (st_reg.dip_cnt < RSC_BOD_CNT_W'(RSC_BOD_MIN_CYC - 1)) begin
      st_next.dip_cnt = st_reg.dip_cnt + RSC_BOD_CNT_W'(1);
    end else begin
      // assert once dip is long enough
      st_next.brownout = 1'b1;
    end

    // one-cycle fetch start on release
    // one cycle after hold falls, so the core starts on a clean cycle
    st_next.hold_prev = tmr_bus.hold;
    st_next.fetch     = st_reg.hold_prev & ~tmr_bus.hold;

    // register write: zeros clear flags, ones keep them; the answer
    // waits until both address and data are held, so either may come
    // first, and awready/wready stay low until the response is taken,
    // which keeps one write at most in flight
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.bvalid = 1'b1;
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      if (st_reg.awaddr[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2]) begin
        st_next.bresp = RSC_RESP_OKAY;
        if (st_reg.wlane) begin
          st_next.status = st_reg.status & st_reg.wdata[RSC_FLAG_W-1:0];
        end
      end else begin
        st_next.bresp = RSC_RESP_DECERR;
      end
    end
    if (aw_fire) begin
      st_next.aw_got  = 1'b1;
      st_next.awaddr  = s_axi_awaddr;
      st_next.awready = 1'b0;
    end
    if (w_fire) begin
      st_next.w_got  = 1'b1;
      st_next.wdata  = s_axi_wdata[7:0];
      st_next.wlane  = s_axi_wstrb[0];
      st_next.wready = 1'b0;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid  = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready  = 1'b1;
    end

    // causes set flags; setting wins over a clearing write
    // a cause still active at the write is not lost; software simply
    // reads the flag set again
    // pin reset flag
    if (!i_pin_reset_n) begin
      st_next.status[RSC_PIN_BIT] = 1'b1;
    end
    if (st_reg.brownout) begin
      st_next.status[RSC_SUPPLY_BIT] = 1'b1;
    end
    if (st_reg.wd_pulse) begin
      st_next.status[RSC_WDOG_BIT] = 1'b1;
    end
    if (i_scan_reset_bit) begin
      st_next.status[RSC_SCAN_BIT] = 1'b1;
    end
    // power-on sets bit 0, clears others
    if (i_supply_below_por) begin
      st_next.status = RSC_FLAG_W'(1) << RSC_POR_BIT;
    end

    // register read: data and response are captured at the address
    // handshake and stand until rready; arready stays low meanwhile
    if (ar_fire) begin
      st_next.arready = 1'b0;
      st_next.rvalid  = 1'b1;
      if (s_axi_araddr[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2]) begin
        st_next.rdata = {{(RSC_STATUS_W - RSC_FLAG_W){1'b0}},
                         st_reg.status};
        st_next.rresp = RSC_RESP_OKAY;
      end else begin
        st_next.rdata = 8'h00;
        st_next.rresp = RSC_RESP_DECERR;
      end
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid  = 1'b0;
      st_next.arready = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // power-up of this logic is a power-on cause
      st_reg.status    <= RSC_STATUS_RST;
      st_reg.wd_pulse  <= 1'b0;
      st_reg.wd_prev   <= 1'b0;
      st_reg.dip_cnt   <= '0;
      st_reg.brownout  <= 1'b0;
      // high, so the first release still gives a fetch pulse
      st_reg.hold_prev <= 1'b1;
      st_reg.fetch     <= 1'b0;
      st_reg.det_en    <= 1'b0;
      st_reg.level     <= 2'h0;
      st_reg.delay     <= CNT_W'(TOUT_BASE_CYC);

      // bus idle and ready to take a request
      st_reg.awready   <= 1'b1;
      st_reg.aw_got    <= 1'b0;
      st_reg.awaddr    <= '0;
      st_reg.wready    <= 1'b1;
      st_reg.w_got     <= 1'b0;
      st_reg.wdata     <= 8'h00;
      st_reg.wlane     <= 1'b0;
      st_reg.bvalid    <= 1'b0;
      st_reg.bresp     <= RSC_RESP_OKAY;
      st_reg.arready   <= 1'b1;
      st_reg.rvalid    <= 1'b0;
      st_reg.rdata     <= 8'h00;
      st_reg.rresp     <= RSC_RESP_OKAY;
    end else begin
      st_reg <= st_next;
    end
  end

  // pin and power-on act on the timer flop directly, so they reach the
  // port pins with no clock; the other sources are sampled at i_clk
  // five sources merged
  assign tmr_bus.clk          = i_clk;
  assign tmr_bus.async_hold_n = i_rst_n & i_pin_reset_n &
                                ~i_supply_below_por;
  assign tmr_bus.sync_hold    = st_reg.wd_pulse | st_reg.brownout |
                                i_scan_reset_bit;
  assign tmr_bus.delay_cycles = st_reg.delay;

  rsc_release_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .bus (tmr_bus.timer)
  );

  // hold drives both the core reset and the port pin reset, so the
  // pins follow the asynchronous assertion of the timer flop
  assign o_internal_reset         = tmr_bus.hold;
  assign o_port_reset             = tmr_bus.hold;
  assign o_fetch_at_vector        = st_reg.fetch;
  assign o_supply_detector_enable = st_reg.det_en;
  assign o_supply_trigger_level   = st_reg.level;

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready  = st_reg.wready;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rresp   = st_reg.rresp;
  assign s_axi_rdata   = {24'h000000, st_reg.rdata};

endmodule
`default_nettype wire
